// File: design/tioc_pkg.sv
// Contract
// - NO input: contact closed means active
// - NC input: contact open means active
// - Reset-function terminal always uses NO polarity
// - Per-terminal sampling time, 0-200, 2-400 ms
// - No sampling delay after power-up or reset
// - Each output driven by selected status code
// - NO output conducts while signal active
// - NC output opens while signal active
// - Zero delay: output follows condition immediately
// - On-delay 0.0-100.0 s before activation
// - Off-delay 0.0-100.0 s before release
// - Duplicate input function kept by last terminal
package tioc_pkg;
   localparam int               NUM_INPUTS        = 5;
   localparam int               NUM_OUTPUTS       = 2;
   localparam int               OUT_OC            = 0;
   localparam int               OUT_RELAY         = 1;
   localparam int               STATUS_WIDTH      = 64;
   localparam int               CLK_PERIOD_NS     = 10;
   // Input sampling granule and output delay granule
   localparam int               SAMPLE_STEP_NS    = 2_000_000;
   localparam int               DELAY_STEP_NS     = 100_000_000;
   localparam int               SAMPLE_STEP_CYC   = SAMPLE_STEP_NS / CLK_PERIOD_NS;
   localparam int               DELAY_STEP_CYC    = DELAY_STEP_NS / CLK_PERIOD_NS;
   localparam logic [7:0]       SAMPLE_TIME_MAX   = 8'hc8;
   localparam logic [9:0]       DELAY_MAX         = 10'h3e8;
   localparam logic [7:0]       FUNC_NONE         = 8'hff;
   localparam logic [7:0]       FUNC_RESET        = 8'h12;
   localparam logic [7:0]       SRC_NONE          = 8'hff;
   localparam logic             POL_NO            = 1'b0;
   localparam logic             POL_NC            = 1'b1;
   localparam logic [7:0]       FUNC_RESET_VAL    = 8'hff;
   localparam logic [8:0]       FILT_CNT_RESET    = 9'h000;
   localparam logic [10:0]      DELAY_CNT_RESET   = 11'h000;

   typedef struct packed {
      logic       polarity;
      logic [7:0] sampleTime;
   } tioc_in_cfg_t;

   typedef struct packed {
      logic [7:0] sourceSel;
      logic       polarity;
      logic [9:0] onDelay;
      logic [9:0] offDelay;
   } tioc_out_cfg_t;

   typedef struct packed {
      logic       write;
      logic [2:0] terminal;
      logic [7:0] func;
   } tioc_func_wr_t;

   typedef enum logic [1:0] {
      TIOC_IDLE     = 2'b00,
      TIOC_ON_PEND  = 2'b01,
      TIOC_ACTIVE   = 2'b11,
      TIOC_OFF_PEND = 2'b10
   } tioc_out_state_t;
endpackage

// File: design/tioc_input_filter.sv
`timescale 1ns/10ps
module tioc_input_filter (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       rawLevel,
   input  wire logic [7:0] sampleTime,
   input  wire logic       tick,
   input  wire logic       bypass,
   output logic            level
);
   import tioc_pkg::*;

   logic [8:0] count;
   logic [8:0] next_count;
   logic       next_level;
   logic [8:0] limit;

   // -------------------------------------------------------------
   // Debounce
   // -------------------------------------------------------------
   // One extra granule so a partial first granule never shortens it
   assign limit = {1'b0, sampleTime} + 9'h002;

   always_comb begin
      next_level = level;
      next_count = count;
      if (bypass) begin
         next_level = rawLevel;
         next_count = FILT_CNT_RESET;
      end else if (rawLevel == level) begin
         next_count = FILT_CNT_RESET;
      end else if (tick) begin
         next_count = count + 9'h001;
         if (next_count >= limit) begin
            next_level = rawLevel;
            next_count = FILT_CNT_RESET;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         level <= 1'b0;
         count <= FILT_CNT_RESET;
      end else begin
         level <= next_level;
         count <= next_count;
      end
   end

   AST_FILT_GLITCH: assert property (@(posedge clk) disable iff (sys_rst)
      (!bypass && !$past(bypass) && level != $past(level)) |-> $past(tick))
      else $error("Filtered level changed without a sampling granule");
   AST_FILT_BYPASS: assert property (@(posedge clk) disable iff (sys_rst)
      bypass |=> level == $past(rawLevel))
      else $error("Level did not follow raw input during bypass");
endmodule // tioc_input_filter

// File: design/tioc_output_timer.sv
`timescale 1ns/10ps
module tioc_output_timer (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       cond,
   input  wire logic [9:0] onDelay,
   input  wire logic [9:0] offDelay,
   input  wire logic       tick,
   output logic            active
);
   import tioc_pkg::*;

   tioc_out_state_t state;
   tioc_out_state_t next_state;
   logic [10:0]     count;
   logic [10:0]     next_count;
   logic [10:0]     bumped;

   // -------------------------------------------------------------
   // Delay state machine
   // -------------------------------------------------------------
   assign bumped = count + 11'h001;

   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         TIOC_IDLE: begin
            next_count = DELAY_CNT_RESET;
            if (cond) begin
               next_state = (onDelay == 10'h000) ? TIOC_ACTIVE : TIOC_ON_PEND;
            end
         end
         TIOC_ON_PEND: begin
            if (!cond) begin
               next_state = TIOC_IDLE;
            end else if (tick) begin
               next_count = bumped;
               if (bumped > {1'b0, onDelay}) begin
                  next_state = TIOC_ACTIVE;
               end
            end
         end
         TIOC_ACTIVE: begin
            next_count = DELAY_CNT_RESET;
            if (!cond) begin
               next_state = (offDelay == 10'h000) ? TIOC_IDLE : TIOC_OFF_PEND;
            end
         end
         TIOC_OFF_PEND: begin
            if (cond) begin
               next_state = TIOC_ACTIVE;
               next_count = DELAY_CNT_RESET;
            end else if (tick) begin
               next_count = bumped;
               if (bumped > {1'b0, offDelay}) begin
                  next_state = TIOC_IDLE;
               end
            end
         end
         default: begin
            next_state = TIOC_IDLE;
            next_count = DELAY_CNT_RESET;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= TIOC_IDLE;
         count <= DELAY_CNT_RESET;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign active = (state == TIOC_ACTIVE) || (state == TIOC_OFF_PEND);

   AST_OUT_NODELAY_ON: assert property (@(posedge clk) disable iff (sys_rst)
      (state == TIOC_IDLE && cond && onDelay == 10'h000) |=> active)
      else $error("Zero on-delay did not activate on next edge");
   AST_OUT_NODELAY_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      (state == TIOC_ACTIVE && !cond && offDelay == 10'h000) |=> !active)
      else $error("Zero off-delay did not release on next edge");
   AST_OUT_CANCEL_ON: assert property (@(posedge clk) disable iff (sys_rst)
      (state == TIOC_ON_PEND && !cond) |=> state == TIOC_IDLE)
      else $error("Pending on-delay not cancelled");
   AST_OUT_CANCEL_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      (state == TIOC_OFF_PEND && cond) |=> state == TIOC_ACTIVE)
      else $error("Pending off-delay not cancelled");
   AST_OUT_ON_EARLY: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(active) |->
         ($past(state) == TIOC_ON_PEND ? $past(tick) : $past(onDelay) == 10'h000))
      else $error("Activated without its delay");
   AST_OUT_ON_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
      ($past(state) == TIOC_ON_PEND && state == TIOC_ACTIVE) |->
         $past(count) + 11'h001 > {1'b0, $past(onDelay)})
      else $error("On-delay expired before its count");
endmodule // tioc_output_timer

// File: design/tioc_terminal_io.sv
`timescale 1ns/10ps
module tioc_terminal_io #(
   parameter int SAMPLE_STEP_CYCLES = tioc_pkg::SAMPLE_STEP_CYC,
   parameter int DELAY_STEP_CYCLES  = tioc_pkg::DELAY_STEP_CYC
) (
   input  wire logic                                  clk,
   input  wire logic                                  sys_rst,
   input  wire logic [tioc_pkg::NUM_INPUTS-1:0]       contactClosed,
   input  tioc_pkg::tioc_in_cfg_t [tioc_pkg::NUM_INPUTS-1:0]   inputCfg,
   input  tioc_pkg::tioc_func_wr_t                    funcWrite,
   input  wire logic [tioc_pkg::STATUS_WIDTH-1:0]     statusBus,
   input  tioc_pkg::tioc_out_cfg_t [tioc_pkg::NUM_OUTPUTS-1:0] outputCfg,
   output logic [tioc_pkg::NUM_INPUTS-1:0]            inputActive,
   output logic [tioc_pkg::NUM_INPUTS-1:0][7:0]       inputFunc,
   output logic                                       resetFunctionActive,
   output logic [tioc_pkg::NUM_OUTPUTS-1:0]           outputCondition,
   output logic                                       openCollectorConduct,
   output logic                                       relayEnergize
);
   import tioc_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic selectSource(input logic [STATUS_WIDTH-1:0] bus,
                                         input logic [7:0]              code);
      logic hit;
      hit = 1'b0;
      if (code != SRC_NONE && code < 8'(STATUS_WIDTH)) begin
         hit = bus[code[5:0]];
      end
      return hit;
   endfunction

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [NUM_INPUTS-1:0] syncStage1;
   logic [NUM_INPUTS-1:0] syncStage2;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         syncStage1 <= '0;
         syncStage2 <= '0;
      end else begin
         syncStage1 <= contactClosed;
         syncStage2 <= syncStage1;
      end
   end

   // -------------------------------------------------------------
   // Granule prescalers
   // -------------------------------------------------------------
   logic [31:0] sampleDiv;
   logic [31:0] next_sampleDiv;
   logic [31:0] delayDiv;
   logic [31:0] next_delayDiv;
   logic        sampleTick;
   logic        delayTick;

   assign sampleTick = (sampleDiv == 32'(SAMPLE_STEP_CYCLES - 1));
   assign delayTick  = (delayDiv == 32'(DELAY_STEP_CYCLES - 1));

   always_comb begin
      next_sampleDiv = sampleTick ? 32'h0000_0000 : sampleDiv + 32'h0000_0001;
      next_delayDiv  = delayTick ? 32'h0000_0000 : delayDiv + 32'h0000_0001;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sampleDiv <= 32'h0000_0000;
         delayDiv  <= 32'h0000_0000;
      end else begin
         sampleDiv <= next_sampleDiv;
         delayDiv  <= next_delayDiv;
      end
   end

   // -------------------------------------------------------------
   // Start-up bypass
   // -------------------------------------------------------------
   // Held until the first granule so the synchronisers have settled
   logic startBypass;
   logic next_startBypass;

   always_comb begin
      next_startBypass = startBypass;
      if (sampleTick) begin
         next_startBypass = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         startBypass <= 1'b1;
      end else begin
         startBypass <= next_startBypass;
      end
   end

   // -------------------------------------------------------------
   // Input function table
   // -------------------------------------------------------------
   logic [NUM_INPUTS-1:0][7:0] funcTable;
   logic [NUM_INPUTS-1:0][7:0] next_funcTable;

   always_comb begin
      next_funcTable = funcTable;
      if (funcWrite.write && funcWrite.terminal < 3'(NUM_INPUTS)) begin
         for (int i = 0; i < NUM_INPUTS; i++) begin
            if (3'(i) == funcWrite.terminal) begin
               next_funcTable[i] = funcWrite.func;
            end else if (funcWrite.func != FUNC_NONE && funcTable[i] == funcWrite.func) begin
               next_funcTable[i] = FUNC_NONE;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_INPUTS; i++) begin
            funcTable[i] <= FUNC_RESET_VAL;
         end
      end else begin
         funcTable <= next_funcTable;
      end
   end

   assign inputFunc = funcTable;

   // -------------------------------------------------------------
   // Input polarity and debounce
   // -------------------------------------------------------------
   logic [NUM_INPUTS-1:0] logicalRaw;
   logic [NUM_INPUTS-1:0] invertEff;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
         // Reset terminal ignores an NC setting
         assign invertEff[gi]  = (inputCfg[gi].polarity == POL_NC) &&
                                 (funcTable[gi] != FUNC_RESET);
         // Closed contact reads active unless inverted
         assign logicalRaw[gi] = syncStage2[gi] ^ invertEff[gi];

         tioc_input_filter u_filter (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .rawLevel   (logicalRaw[gi]),
            .sampleTime (inputCfg[gi].sampleTime),
            .tick       (sampleTick),
            .bypass     (startBypass),
            .level      (inputActive[gi])
         );
      end
   endgenerate

   always_comb begin
      resetFunctionActive = 1'b0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         if (funcTable[i] == FUNC_RESET && inputActive[i]) begin
            resetFunctionActive = 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // Output source, delay and polarity
   // -------------------------------------------------------------
   logic [NUM_OUTPUTS-1:0] condRaw;
   logic [NUM_OUTPUTS-1:0] delayedActive;
   logic [NUM_OUTPUTS-1:0] pinDrive;
   logic [NUM_OUTPUTS-1:0] next_pinDrive;

   generate
      for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_output
         assign condRaw[gi] = selectSource(statusBus, outputCfg[gi].sourceSel);

         tioc_output_timer u_timer (
            .clk      (clk),
            .sys_rst  (sys_rst),
            .cond     (condRaw[gi]),
            .onDelay  (outputCfg[gi].onDelay),
            .offDelay (outputCfg[gi].offDelay),
            .tick     (delayTick),
            .active   (delayedActive[gi])
         );
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
         // NO conducts when active, NC opens when active
         next_pinDrive[i] = delayedActive[i] ^ (outputCfg[i].polarity == POL_NC);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinDrive <= '0;
      end else begin
         pinDrive <= next_pinDrive;
      end
   end

   assign outputCondition      = delayedActive;
   assign openCollectorConduct = pinDrive[OUT_OC];
   assign relayEnergize        = pinDrive[OUT_RELAY];

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   AST_OC_POLARITY: assert property (@(posedge clk) disable iff (sys_rst)
      (outputCfg[OUT_OC].polarity == POL_NO) |=>
         openCollectorConduct == $past(delayedActive[OUT_OC]))
      else $error("NO open-collector output does not follow its signal");
   AST_RELAY_POLARITY: assert property (@(posedge clk) disable iff (sys_rst)
      (outputCfg[OUT_RELAY].polarity == POL_NC) |=>
         relayEnergize == !$past(delayedActive[OUT_RELAY]))
      else $error("NC relay output not inverted");
   AST_SRC_NONE: assert property (@(posedge clk) disable iff (sys_rst)
      (outputCfg[OUT_OC].sourceSel == SRC_NONE) |-> !condRaw[OUT_OC])
      else $error("Unassigned output source reads active");
   AST_RESET_TERM_NO: assert property (@(posedge clk) disable iff (sys_rst)
      (funcTable[2] == FUNC_RESET) |-> logicalRaw[2] == syncStage2[2])
      else $error("Reset terminal not read as NO contact");
   AST_FUNC_UNIQUE: assert property (@(posedge clk) disable iff (sys_rst)
      (funcTable[4] != FUNC_NONE) |-> funcTable[4] != funcTable[2])
      else $error("Input function held by two terminals");
   AST_INPUT_NC: assert property (@(posedge clk) disable iff (sys_rst)
      (inputCfg[1].polarity == POL_NC && funcTable[1] != FUNC_RESET) |->
         logicalRaw[1] == !syncStage2[1])
      else $error("NC input not inverted");

   genvar gj;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in_chk
         AST_IN_NO: assert property (
            inputCfg[gi].polarity == POL_NO |-> logicalRaw[gi] == syncStage2[gi])
            else $error("NO input read inverted");

         AST_IN_NC: assert property (
            inputCfg[gi].polarity == POL_NC && funcTable[gi] != FUNC_RESET |->
               logicalRaw[gi] != syncStage2[gi])
            else $error("NC input read as is");

         AST_IN_RESET_NO: assert property (
            funcTable[gi] == FUNC_RESET |-> logicalRaw[gi] == syncStage2[gi])
            else $error("Reset terminal read inverted");

         AST_IN_RESET_FLAG: assert property (
            funcTable[gi] == FUNC_RESET && inputActive[gi] |-> resetFunctionActive)
            else $error("Active reset terminal not flagged");

         AST_IN_SETTLE: assert property (
            !startBypass && !sampleTick |=> $stable(inputActive[gi]))
            else $error("Input changed between granules");

         AST_FUNC_TAKE: assert property (
            funcWrite.write && funcWrite.terminal == 3'(gi) |=>
               funcTable[gi] == $past(funcWrite.func))
            else $error("Function write not taken");

         for (gj = gi + 1; gj < NUM_INPUTS; gj++) begin : g_pair
            AST_FUNC_PAIR: assert property (
               funcTable[gi] != FUNC_NONE |-> funcTable[gi] != funcTable[gj])
               else $error("Function held twice");
         end
      end

      for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_out_chk
         AST_SRC_PICK: assert property (
            outputCfg[gi].sourceSel < 8'(STATUS_WIDTH) |->
               condRaw[gi] == statusBus[outputCfg[gi].sourceSel[5:0]])
            else $error("Wrong status bit selected");

         AST_SRC_OFF: assert property (
            outputCfg[gi].sourceSel >= 8'(STATUS_WIDTH) |-> !condRaw[gi])
            else $error("Unassigned source reads active");

         AST_PIN_NO: assert property (
            outputCfg[gi].polarity == POL_NO |=> pinDrive[gi] == $past(delayedActive[gi]))
            else $error("NO output pin inverted");

         AST_PIN_NC: assert property (
            outputCfg[gi].polarity == POL_NC |=> pinDrive[gi] != $past(delayedActive[gi]))
            else $error("NC output pin not inverted");
      end
   endgenerate

   AST_BYPASS_END: assert property (
      startBypass && sampleTick |=> !startBypass)
      else $error("Bypass outlived first granule");

   AST_BYPASS_ONCE: assert property (
      !startBypass |=> !startBypass)
      else $error("Bypass returned without reset");

   AST_FUNC_REFUSE: assert property (
      funcWrite.write && funcWrite.terminal >= 3'(NUM_INPUTS) |=> $stable(funcTable))
      else $error("Missing terminal changed table");
endmodule // tioc_terminal_io

// File: dv/tioc_contact_model.sv
`timescale 1ns/10ps
module tioc_contact_model (
   input  wire logic       clk,
   input  wire logic [4:0] target,
   input  wire logic [4:0] bounce,
   output logic      [4:0] contactClosed
);
   logic [4:0] phase;

   initial begin
      phase = 5'h00;
      contactClosed = 5'h00;
   end

   // Chatter: contact flips every cycle while bouncing
   always @(negedge clk) begin
      phase <= ~phase;
      contactClosed <= target ^ (bounce & phase);
   end
endmodule // tioc_contact_model

// File: dv/tioc_terminal_io_tb.sv
`timescale 1ns/10ps
module tioc_terminal_io_tb;
   import tioc_pkg::*;
   localparam int SS = 16;
   localparam int DS = 8;
   logic                              clk;
   logic                              sys_rst;
   logic [4:0]                        target;
   logic [4:0]                        bounce;
   logic [4:0]                        contactClosed;
   tioc_in_cfg_t  [NUM_INPUTS-1:0]    inputCfg;
   tioc_out_cfg_t [NUM_OUTPUTS-1:0]   outputCfg;
   tioc_func_wr_t                     funcWrite;
   logic [63:0]                       statusBus;
   logic [4:0]                        inputActive;
   logic [4:0][7:0]                   inputFunc;
   logic                              resetFunctionActive;
   logic [1:0]                        outputCondition;
   logic [1:0]                        pins;
   int                                seed;
   int                                fails;
   int                                checkCount;
   int                                n;
   bit                                steady;
   logic [7:0]                        st;
   logic [7:0]                        sel;
   logic [4:0]                        pol;
   logic [9:0]                        dOn;
   logic [9:0]                        dOff;

   tioc_contact_model i_contacts (.clk(clk), .target(target), .bounce(bounce),
                                  .contactClosed(contactClosed));

   tioc_terminal_io #(.SAMPLE_STEP_CYCLES(SS), .DELAY_STEP_CYCLES(DS)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .contactClosed(contactClosed), .inputCfg(inputCfg),
      .funcWrite(funcWrite), .statusBus(statusBus), .outputCfg(outputCfg),
      .inputActive(inputActive), .inputFunc(inputFunc),
      .resetFunctionActive(resetFunctionActive), .outputCondition(outputCondition),
      .openCollectorConduct(pins[0]), .relayEnergize(pins[1]));

   always #5 clk = ~clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] b8(input logic b);
      return {7'h00, b};
   endfunction

   function automatic logic expPin(input logic [63:0] s, input logic [7:0] c, input logic p);
      return ((c < 8'h40) ? s[c[5:0]] : 1'b0) ^ p;
   endfunction

   function automatic logic cur(input bit isOut, input int i);
      return isOut ? outputCondition[i] : inputActive[i];
   endfunction

   task automatic conclude;
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask

   task automatic waitFor(input bit isOut, input int i, input logic v);
      n = 0;
      while (cur(isOut, i) !== v) begin
         @(negedge clk);
         n++;
         if (n > 4000) begin
            check("wait bound", b8(v), b8(cur(isOut, i)));
            conclude();
         end
      end
   endtask

   task automatic holdOut(input int o, input logic v, input int c);
      repeat (c) begin
         @(negedge clk);
         if (outputCondition[o] !== v) steady = 1'b0;
      end
   endtask

   task automatic funcWr(input logic [2:0] t, input logic [7:0] f);
      funcWrite = '{1'b1, t, f};
      @(negedge clk);
      funcWrite.write = 1'b0;
      @(negedge clk);
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      seed = 936;
      fails = 0;
      checkCount = 0;
      clk = 1'b0;
      sys_rst = 1'b1;
      target = 5'h1f;
      bounce = 5'h00;
      statusBus = 64'h0;
      funcWrite = '0;
      for (int i = 0; i < NUM_INPUTS; i++) inputCfg[i] = '{POL_NO, SAMPLE_TIME_MAX};
      for (int i = 0; i < NUM_OUTPUTS; i++) outputCfg[i] = '{SRC_NONE, POL_NO, 10'h0, 10'h0};
      cyc(3);
      sys_rst = 1'b0;
      cyc(8);
      check("startup inputs", 8'h1f, {3'h0, inputActive});
      $display("test startup done");
      for (int r = 0; r < 4; r++) begin
         pol = 5'($random(seed));
         st = 8'($random(seed)) & 8'h03;
         target = 5'($random(seed));
         for (int i = 0; i < NUM_INPUTS; i++) inputCfg[i] = '{pol[i], st};
         cyc((st + 2) * SS + 8);
         check("polarity", {3'h0, target ^ pol}, {3'h0, inputActive});
      end
      $display("test polarity done");
      for (int r = 0; r < 4; r++) begin
         st = (r == 0) ? 8'h00 : (r == 1) ? SAMPLE_TIME_MAX : 8'($random(seed)) & 8'h07;
         inputCfg[0] = '{POL_NO, st};
         waitFor(1'b0, 0, target[0]);
         bounce[0] = 1'b1;
         cyc((st + 2) * SS + 8);
         bounce[0] = 1'b0;
         cyc(4);
         check("chatter", b8(target[0]), b8(inputActive[0]));
         target[0] = ~target[0];
         waitFor(1'b0, 0, target[0]);
         check("response", 8'h01, b8(n >= (st + 1) * SS && n <= (st + 2) * SS + 5));
      end
      $display("test sampling done");
      for (int i = 0; i < NUM_INPUTS; i++) inputCfg[i] = '{POL_NC, 8'h00};
      funcWr(3'h2, FUNC_RESET);
      check("func 2", FUNC_RESET, inputFunc[2]);
      cyc(2 * SS + 8);
      check("reset term", b8(target[2]), b8(inputActive[2]));
      check("reset active", b8(target[2]), b8(resetFunctionActive));
      funcWr(3'h4, FUNC_RESET);
      check("old holder", FUNC_NONE, inputFunc[2]);
      check("new holder", FUNC_RESET, inputFunc[4]);
      funcWr(3'h5, FUNC_RESET);
      check("far terminal", FUNC_RESET, inputFunc[4]);
      cyc(2 * SS + 8);
      check("nc again", b8(~target[2]), b8(inputActive[2]));
      check("reset term 4", b8(target[4]), b8(inputActive[4]));
      $display("test functions done");
      for (int o = 0; o < NUM_OUTPUTS; o++) begin
         for (int r = 0; r < 6; r++) begin
            sel = (r == 0) ? 8'h00 : (r == 1) ? 8'h05 : (r == 2) ? SRC_NONE :
                  (r == 3) ? 8'h40 : 8'($random(seed)) & 8'h3f;
            pol[0] = 1'($random(seed));
            outputCfg[o] = '{sel, pol[0], 10'h0, 10'h0};
            statusBus = {$random(seed), $random(seed)};
            cyc(4);
            statusBus = ~statusBus;
            @(negedge clk);
            check("condition", b8(expPin(statusBus, sel, 1'b0)), b8(outputCondition[o]));
            @(negedge clk);
            check("pin", b8(expPin(statusBus, sel, pol[0])), b8(pins[o]));
         end
      end
      $display("test output select done");
      for (int o = 0; o < NUM_OUTPUTS; o++) begin
         dOn = 10'($random(seed)) & 10'h003;
         dOn = dOn + 10'h001;
         dOff = 10'($random(seed)) & 10'h003;
         dOff = dOff + 10'h001;
         statusBus = 64'h0;
         outputCfg[o] = '{8'h07, POL_NO, dOn, dOff};
         cyc((dOn + dOff + 4) * DS);
         steady = 1'b1;
         statusBus[7] = 1'b1;
         holdOut(o, 1'b0, dOn * DS - 2);
         statusBus[7] = 1'b0;
         holdOut(o, 1'b0, 2 * DS);
         check("on cancel", 8'h01, b8(steady));
         statusBus[7] = 1'b1;
         waitFor(1'b1, o, 1'b1);
         check("on delay", 8'h01, b8(n >= dOn * DS && n <= (dOn + 1) * DS + 2));
         @(negedge clk);
         check("on pin", 8'h01, b8(pins[o]));
         statusBus[7] = 1'b0;
         holdOut(o, 1'b1, dOff * DS - 2);
         statusBus[7] = 1'b1;
         holdOut(o, 1'b1, 2 * DS);
         check("off cancel", 8'h01, b8(steady));
         statusBus[7] = 1'b0;
         waitFor(1'b1, o, 1'b0);
         check("off delay", 8'h01, b8(n >= dOff * DS && n <= (dOff + 1) * DS + 2));
      end
      $display("test output delay done");
      sys_rst = 1'b1;
      for (int i = 0; i < NUM_INPUTS; i++) inputCfg[i] = '{POL_NO, SAMPLE_TIME_MAX};
      target = ~inputActive;
      cyc(2);
      check("func cleared", FUNC_NONE, inputFunc[4]);
      sys_rst = 1'b0;
      cyc(8);
      check("restart inputs", {3'h0, target}, {3'h0, inputActive});
      $display("test restart done");
      conclude();
   end
endmodule // tioc_terminal_io_tb
